/* iex_core.v */
`timescale 1ns/10ps
`default_nettype none
`include "iex_regs.vh"
module iex_core #(
   parameter PCW = 21
) (
   input wire clk,
   input wire arst_n,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire [15:0] instr_i,
   input wire [11:0] idx_base_i,
   input wire [7:0] dm_rdata_i,
   output reg [PCW-1:0] pc_o,
   output reg [3:0] phase_o,
   output reg [11:0] dm_addr_o,
   output reg dm_rd_o,
   output reg dm_wr_o,
   output reg [7:0] dm_wdata_o
);
   localparam [3:0] PH_Q1 = 4'h1;
   localparam [3:0] PH_Q2 = 4'h2;
   localparam [3:0] PH_Q3 = 4'h4;
   localparam [3:0] PH_Q4 = 4'h8;

   reg [3:0] phase_q;
   reg [1:0] ctrl_q;
   reg [7:0] w_q;
   reg [4:0] stat_q;
   reg [3:0] bank_q;
   reg ill_q;
   reg [15:0] ir_q;
   reg [5:0] op_q;
   reg [7:0] res_q;
   reg [4:0] flag_new_q;
   reg take_q;
   reg flush_q;
   reg [5:0] dec_d;
   reg [11:0] addr_d;
   reg rd_need_d;
   reg [31:0] rdat_d;
   wire [7:0] alu_res;
   wire [4:0] alu_flags;
   wire bus_req;
   wire bus_wr;
   wire advance;
   wire [PCW-1:0] pc_inc;
   wire [PCW-1:0] pc_jump;
   wire dest_file;
   wire writes_acc;
   wire writes_file;
   wire updates_flags;
   wire [PCW-1:0] br_ofs;

   assign bus_req = wb_cyc_i & wb_stb_i;
   // Write commits on the acknowledged edge only
   assign bus_wr = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
   // Stops only at an instruction boundary
   assign advance = ctrl_q[`IEX_CTRL_RUN] | (phase_q != PH_Q1);
   assign pc_inc = pc_o + {{(PCW-2){1'b0}}, 2'b10};
   // target is PC + 2 + 2n
   assign br_ofs = {{(PCW-9){ir_q[7]}}, ir_q[7:0], 1'b0};
   assign pc_jump = pc_o + br_ofs;
   // destination bit picks W or file
   assign dest_file = ir_q[9];
   // and result back to same file
   assign writes_file = ((op_q == `IEX_SEL_ADDC) | (op_q == `IEX_SEL_ANDF)) & dest_file
                        | (op_q == `IEX_SEL_BCLR);
   assign writes_acc = ((op_q == `IEX_SEL_ADDC) | (op_q == `IEX_SEL_ANDF)) & ~dest_file
                       | (op_q == `IEX_SEL_ANDL);
   // only flag ops update
   // Idle and illegal slots keep STATUS, so a stale Q3 copy never lands
   assign updates_flags = (op_q == `IEX_SEL_ADDC) | (op_q == `IEX_SEL_ANDF) | (op_q == `IEX_SEL_ANDL);

   iex_alu u_alu (
      .op_sel(op_q),
      .acc(w_q),
      .opnd(dm_rdata_i),
      .lit(ir_q[7:0]),
      .bit_sel(ir_q[11:9]),
      .flags_in(stat_q),
      .result(alu_res),
      .flags_out(alu_flags)
   );

   always @* begin
      dec_d = 6'h00;
      if (instr_i[15:10] == `IEX_OP_ADDC) begin
         dec_d = `IEX_SEL_ADDC;
      end else if (instr_i[15:10] == `IEX_OP_ANDF) begin
         dec_d = `IEX_SEL_ANDF;
      end else if (instr_i[15:8] == `IEX_OP_ANDL) begin
         dec_d = `IEX_SEL_ANDL;
      end else if (instr_i[15:12] == `IEX_OP_BCLR) begin
         dec_d = `IEX_SEL_BCLR;
      end else if (instr_i[15:8] == `IEX_OP_BRC) begin
         dec_d = `IEX_SEL_BRC;
      end else if (instr_i[15:8] == `IEX_OP_BRN) begin
         dec_d = `IEX_SEL_BRN;
      end
      rd_need_d = (dec_d == `IEX_SEL_ADDC) | (dec_d == `IEX_SEL_ANDF) | (dec_d == `IEX_SEL_BCLR);
   end

   always @* begin
      addr_d = {4'h0, instr_i[7:0]};
      if (instr_i[8]) begin
         addr_d = {bank_q, instr_i[7:0]};
      end else if (ctrl_q[`IEX_CTRL_EXT] && (instr_i[7:0] <= `IEX_IDX_LIMIT)) begin
         addr_d = idx_base_i + {4'h0, instr_i[7:0]};
      end else if (instr_i[7:0] >= `IEX_ACC_SPLIT) begin
         addr_d = {`IEX_ACC_HIGH, instr_i[7:0]};
      end
   end

   always @* begin
      rdat_d = 32'h0000_0000;
      case (wb_adr_i)
         `IEX_ADR_CTRL: begin
            rdat_d[1:0] = ctrl_q;
         end
         `IEX_ADR_WREG: begin
            rdat_d[7:0] = w_q;
         end
         `IEX_ADR_STAT: begin
            rdat_d[4:0] = stat_q;
         end
         `IEX_ADR_BANK: begin
            rdat_d[3:0] = bank_q;
         end
         `IEX_ADR_PC: begin
            rdat_d[PCW-1:0] = pc_o;
         end
         `IEX_ADR_INFO: begin
            rdat_d[`IEX_INFO_ILL] = ill_q;
            rdat_d[7:4] = phase_q;
         end
         default: begin
            rdat_d = 32'h0000_0000;
         end
      endcase
   end

   // Bus slave, one wait state
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req & ~wb_ack_o;
         if (bus_req & ~wb_ack_o) begin
            wb_dat_o <= rdat_d;
         end else begin
            wb_dat_o <= 32'h0000_0000;
         end
      end
   end

   // Phase sequencer
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_q <= PH_Q1;
         phase_o <= PH_Q1;
      end else if (advance) begin
         case (phase_q)
            PH_Q1: begin
               phase_q <= PH_Q2;
               phase_o <= PH_Q2;
            end
            PH_Q2: begin
               phase_q <= PH_Q3;
               phase_o <= PH_Q3;
            end
            PH_Q3: begin
               phase_q <= PH_Q4;
               phase_o <= PH_Q4;
            end
            PH_Q4: begin
               phase_q <= PH_Q1;
               phase_o <= PH_Q1;
            end
            default: begin
               phase_q <= PH_Q1;
               phase_o <= PH_Q1;
            end
         endcase
      end
   end

   // Execution datapath
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q <= `IEX_CTRL_RST;
         w_q <= 8'h00;
         stat_q <= `IEX_STAT_RST;
         bank_q <= 4'h0;
         ill_q <= 1'b0;
         pc_o <= {PCW{1'b0}};
         ir_q <= 16'h0000;
         op_q <= 6'h00;
         res_q <= 8'h00;
         flag_new_q <= `IEX_STAT_RST;
         take_q <= 1'b0;
         flush_q <= 1'b0;
         dm_addr_o <= 12'h000;
         dm_rd_o <= 1'b0;
         dm_wr_o <= 1'b0;
         dm_wdata_o <= 8'h00;
      end else begin
         // Software writes; core updates below take precedence
         if (bus_wr) begin
            case (wb_adr_i)
               `IEX_ADR_CTRL: ctrl_q <= wb_dat_i[1:0];
               `IEX_ADR_WREG: w_q <= wb_dat_i[7:0];
               `IEX_ADR_STAT: stat_q <= wb_dat_i[4:0];
               `IEX_ADR_BANK: bank_q <= wb_dat_i[3:0];
               `IEX_ADR_PC: pc_o <= wb_dat_i[PCW-1:0];
               `IEX_ADR_INFO: begin
                  if (wb_dat_i[`IEX_INFO_ILL]) begin
                     ill_q <= 1'b0;
                  end
               end
               default: begin
                  ctrl_q <= ctrl_q;
               end
            endcase
         end
         if (advance) begin
            case (phase_q)
               PH_Q1: begin
                  if (flush_q) begin
                     // Word on instr_i ignored, PC held
                     // second branch cycle idles
                     flush_q <= 1'b0;
                     op_q <= 6'h00;
                     dm_rd_o <= 1'b0;
                  end else begin
                     ir_q <= instr_i;
                     op_q <= dec_d;
                     pc_o <= pc_inc;
                     dm_addr_o <= addr_d;
                     dm_rd_o <= rd_need_d;
                     // Set wins over a same-cycle clear
                     if (dec_d == 6'h00) begin
                        ill_q <= 1'b1;
                     end
                  end
               end
               PH_Q2: begin
                  dm_rd_o <= 1'b0;
               end
               PH_Q3: begin
                  res_q <= alu_res;
                  flag_new_q <= alu_flags;
                  // Flags as they stand in Q3 decide
                  // carry and negative branch conditions
                  take_q <= ((op_q == `IEX_SEL_BRC) & stat_q[`IEX_ST_C])
                            | ((op_q == `IEX_SEL_BRN) & stat_q[`IEX_ST_N]);
                  dm_wr_o <= writes_file;
                  dm_wdata_o <= alu_res;
               end
               PH_Q4: begin
                  dm_wr_o <= 1'b0;
                  take_q <= 1'b0;
                  if (writes_acc) begin
                     w_q <= res_q;
                  end
                  if (updates_flags) begin
                     stat_q <= flag_new_q;
                  end
                  if (take_q) begin
                     pc_o <= pc_jump;
                     flush_q <= 1'b1;
                  end
               end
               default: begin
                  dm_rd_o <= 1'b0;
                  dm_wr_o <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule // iex_core
`default_nettype wire

/* iex_regs.vh */
`ifndef IEX_REGS_VH
`define IEX_REGS_VH
// Wishbone byte offsets
`define IEX_ADR_CTRL 8'h00
`define IEX_ADR_WREG 8'h04
`define IEX_ADR_STAT 8'h08
`define IEX_ADR_BANK 8'h0C
`define IEX_ADR_PC 8'h10
`define IEX_ADR_INFO 8'h14
// Control fields
`define IEX_CTRL_RUN 0
`define IEX_CTRL_EXT 1
`define IEX_CTRL_RST 2'h0
// Status flag positions
`define IEX_ST_C 0
`define IEX_ST_DC 1
`define IEX_ST_Z 2
`define IEX_ST_OV 3
`define IEX_ST_N 4
`define IEX_STAT_RST 5'h00
// Info fields
`define IEX_INFO_ILL 0
// Opcode patterns
`define IEX_OP_ADDC 6'h08
`define IEX_OP_ANDF 6'h05
`define IEX_OP_ANDL 8'h0B
`define IEX_OP_BCLR 4'h9
`define IEX_OP_BRC 8'hE2
`define IEX_OP_BRN 8'hE6
// Addressing
`define IEX_IDX_LIMIT 8'h5F
`define IEX_ACC_SPLIT 8'h60
`define IEX_ACC_HIGH 4'hF
// Operation select, one-hot
`define IEX_SEL_ADDC 6'h01
`define IEX_SEL_ANDF 6'h02
`define IEX_SEL_ANDL 6'h04
`define IEX_SEL_BCLR 6'h08
`define IEX_SEL_BRC 6'h10
`define IEX_SEL_BRN 6'h20
`endif

/* iex_alu.v */
`timescale 1ns/10ps
`default_nettype none
`include "iex_regs.vh"
module iex_alu (
   input wire [5:0] op_sel,
   input wire [7:0] acc,
   input wire [7:0] opnd,
   input wire [7:0] lit,
   input wire [2:0] bit_sel,
   input wire [4:0] flags_in,
   output reg [7:0] result,
   output reg [4:0] flags_out
);
   reg [8:0] sum;
   reg [4:0] low;
   always @* begin
      sum = {1'b0, acc} + {1'b0, opnd} + {8'h00, flags_in[`IEX_ST_C]};
      low = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, flags_in[`IEX_ST_C]};
      result = 8'h00;
      flags_out = flags_in;
      case (op_sel)
         `IEX_SEL_ADDC: begin
            result = sum[7:0];
            flags_out[`IEX_ST_C] = sum[8];
            flags_out[`IEX_ST_DC] = low[4];
            flags_out[`IEX_ST_OV] = (acc[7] == opnd[7]) && (sum[7] != acc[7]);
            flags_out[`IEX_ST_N] = sum[7];
            flags_out[`IEX_ST_Z] = (sum[7:0] == 8'h00);
         end
         `IEX_SEL_ANDF: begin
            result = acc & opnd;
            flags_out[`IEX_ST_N] = result[7];
            flags_out[`IEX_ST_Z] = (result == 8'h00);
         end
         `IEX_SEL_ANDL: begin
            result = acc & lit;
            flags_out[`IEX_ST_N] = result[7];
            flags_out[`IEX_ST_Z] = (result == 8'h00);
         end
         `IEX_SEL_BCLR: begin
            result = opnd & ~(8'h01 << bit_sel);
         end
         default: begin
            result = 8'h00;
         end
      endcase
   end
endmodule // iex_alu
`default_nettype wire

/* iex_core_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module iex_core_sva #(parameter PCW = 21) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [15:0] instr_i,
   input wire logic [7:0] dm_rdata_i,
   input wire logic [PCW-1:0] pc_o,
   input wire logic [3:0] phase_o,
   input wire logic [11:0] dm_addr_o,
   input wire logic dm_rd_o,
   input wire logic dm_wr_o,
   input wire logic [7:0] dm_wdata_o
);
   logic [PCW-1:0] pc_q;
   logic [15:0] ir_q;
   // Word and address of the last fetch slot
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pc_q <= '0;
         ir_q <= '0;
      end else if (phase_o == 4'h1) begin
         pc_q <= pc_o;
         ir_q <= instr_i;
      end
   end
   // Idle slot after a taken branch does not advance the PC, so it never counts
   wire fet = phase_o == 4'h2 && pc_o - pc_q == PCW'(2);
   wire [PCW-1:0] tgt = pc_q + PCW'(2) + {{(PCW-9){ir_q[7]}}, ir_q[7:0], 1'b0};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_phase_walk: assert property (phase_o == 4'h2 |=> phase_o == 4'h4 ##1 phase_o == 4'h8 ##1 phase_o == 4'h1)
      else $error("phase order");
   a_read_in_q2: assert property (dm_rd_o |-> phase_o == 4'h2)
      else $error("read outside Q2");
   a_write_in_q4: assert property (dm_wr_o |-> phase_o == 4'h8)
      else $error("write outside Q4");
   a_bclr_data: assert property (fet && ir_q[15:12] == 4'h9 |-> dm_rd_o ##2 dm_wr_o && dm_wdata_o ==
      ($past(dm_rdata_i) & ~(8'h01 << ir_q[11:9]))) else $error("bit clear data");
   a_file_dest: assert property (fet && (ir_q[15:10] == 6'h05 || ir_q[15:10] == 6'h08) |-> dm_rd_o
      ##2 dm_wr_o == ir_q[9] && dm_addr_o == $past(dm_addr_o, 2)) else $error("file destination");
   a_branch_pc: assert property (fet && (ir_q[15:8] == 8'hE2 || ir_q[15:8] == 8'hE6) |-> ##3
      ((pc_o == pc_q + PCW'(2)) or (pc_o == tgt ##1 $stable(pc_o) [*4]))) else $error("branch pc");
   c_taken: cover property (fet && ir_q[15:13] == 3'h7 ##3 pc_o == tgt);
   c_bclr: cover property (fet && ir_q[15:12] == 4'h9);
   c_file_wr: cover property (dm_wr_o && ir_q[15:10] == 6'h05);
endmodule // iex_core_sva
bind iex_core iex_core_sva #(.PCW(PCW)) i_iex_core_sva (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .instr_i(instr_i), .dm_rdata_i(dm_rdata_i), .pc_o(pc_o),
   .phase_o(phase_o), .dm_addr_o(dm_addr_o), .dm_rd_o(dm_rd_o), .dm_wr_o(dm_wr_o), .dm_wdata_o(dm_wdata_o));
`default_nettype wire

/* iex_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module iex_mem_model #(parameter PCW = 21) (
   input wire logic clk,
   input wire logic [PCW-1:0] pc,
   output logic [15:0] instr,
   input wire logic [11:0] addr,
   input wire logic rd,
   input wire logic wr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [15:0] prog [0:127] = '{default: 16'h0000};
   logic [7:0] mem [0:4095] = '{default: 8'h00};
   initial rdata = 8'h00;
   // Small program store, aliases above 0xFF
   assign instr = prog[pc[7:1]];
   // Valid only in Q3; inverted otherwise so a late sample shows
   always @(posedge clk) begin
      rdata <= rd ? mem[addr] : ~rdata;
      if (wr)
         mem[addr] <= wdata;
   end
endmodule // iex_mem_model
`default_nettype wire

/* testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic clk = 1'h0, arst_n = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0, bsel = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rv;
   logic wb_ack_o, dm_rd_o, dm_wr_o;
   logic [15:0] instr_i;
   logic [7:0] dm_rdata_i, dm_wdata_o;
   logic [11:0] dm_addr_o;
   logic [20:0] pc_o;
   logic [3:0] phase_o;
   int mismatches = 0;
   int compares = 0;
   always #5 clk = ~clk;
   iex_core #(.PCW(21)) i_iex_core (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .instr_i(instr_i), .idx_base_i(12'h100), .dm_rdata_i(dm_rdata_i), .pc_o(pc_o),
      .phase_o(phase_o), .dm_addr_o(dm_addr_o), .dm_rd_o(dm_rd_o), .dm_wr_o(dm_wr_o), .dm_wdata_o(dm_wdata_o));
   iex_mem_model #(.PCW(21)) i_iex_mem_model (.clk(clk), .pc(pc_o), .instr(instr_i), .addr(dm_addr_o),
      .rd(dm_rd_o), .wr(dm_wr_o), .wdata(dm_wdata_o), .rdata(dm_rdata_i));
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= bsel;
      wb_dat_i <= d;
      for (n = 0; n < 9 && wb_ack_o !== 1'h1; n++)
         @(posedge clk);
      if (wb_ack_o !== 1'h1)
         chk(wb_ack_o, 1'h1);
      if (wb_ack_o !== 1'h1)
         tally_and_finish;
      rv = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      wb_sel_i <= 4'h0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0);
      chk(rv, e);
   endtask
   task automatic load(input logic [7:0] a, input logic [15:0] w);
      i_iex_mem_model.prog[a[7:1]] = w;
   endtask
   task automatic poke(input logic [11:0] a, input logic [7:0] v);
      i_iex_mem_model.mem[a] = v;
   endtask
   function automatic logic [7:0] peek(input logic [11:0] a);
      return i_iex_mem_model.mem[a];
   endfunction
   // Core owns W and STATUS while running, so these go in only when stopped
   task automatic setup(input logic [7:0] w, input logic [4:0] st, input logic [3:0] bk);
      bus(1'h1, 8'h04, {24'h0, w});
      bus(1'h1, 8'h08, {27'h0, st});
      bus(1'h1, 8'h0C, {28'h0, bk});
   endtask
   task automatic run(input logic [20:0] pc0, input logic [20:0] stop, input logic ext);
      int n;
      bus(1'h1, 8'h10, {11'h0, pc0});
      bus(1'h1, 8'h00, {30'h0, ext, 1'h1});
      for (n = 0; n < 99 && !(pc_o === stop && phase_o === 4'h1); n++)
         @(posedge clk);
      chk(pc_o, stop);
      if (pc_o !== stop)
         tally_and_finish;
      bus(1'h1, 8'h00, {30'h0, ext, 1'h0});
      repeat (8) @(posedge clk);
   endtask
   task automatic t_reset;
      rchk(8'h00, 32'h0);
      rchk(8'h04, 32'h0);
      rchk(8'h08, 32'h0);
      bus(1'h1, 8'h20, 32'hFF);
      rchk(8'h20, 32'h0);
      rchk(8'h0C, 32'h0);
      rchk(8'h10, 32'h0);
      rchk(8'h14, 32'h10);
      // Byte lane 0 off, so the write must be dropped
      bsel = 4'hE;
      bus(1'h1, 8'h04, 32'h5A);
      bsel = 4'hF;
      rchk(8'h04, 32'h0);
      $display("t_reset end");
   endtask
   task automatic t_addc;
      load(8'h00, 16'h2102);
      load(8'h02, 16'h2280);
      poke(12'h302, 8'h02);
      poke(12'hF80, 8'h7F);
      setup(8'h4D, 5'h01, 4'h3);
      run(21'h0, 21'h4, 1'h0);
      rchk(8'h04, 32'h50);
      rchk(8'h08, 32'h18);
      chk(peek(12'hF80), 32'hCF);
      // Blank word at the stop address runs before run drops
      rchk(8'h14, 32'h11);
      bus(1'h1, 8'h14, 32'h1);
      rchk(8'h14, 32'h10);
      $display("t_addc end");
   endtask
   task automatic t_andl;
      load(8'h10, 16'h0BF0);
      load(8'h12, 16'h0B5F);
      setup(8'hA3, 5'h1F, 4'h0);
      run(21'h10, 21'h14, 1'h0);
      rchk(8'h04, 32'h00);
      rchk(8'h08, 32'h0F);
      $display("t_andl end");
   endtask
   task automatic t_andf;
      load(8'h20, 16'h165F);
      load(8'h22, 16'h1460);
      poke(12'h15F, 8'hC2);
      poke(12'hF60, 8'h94);
      setup(8'h17, 5'h15, 4'h0);
      run(21'h20, 21'h24, 1'h1);
      chk(peek(12'h15F), 32'h02);
      chk(peek(12'hF60), 32'h94);
      rchk(8'h04, 32'h14);
      rchk(8'h08, 32'h01);
      $display("t_andf end");
   endtask
   task automatic t_bclr;
      load(8'h30, 16'h9E47);
      load(8'h32, 16'h9110);
      poke(12'h047, 8'hC7);
      poke(12'h210, 8'hFF);
      setup(8'h55, 5'h1F, 4'h2);
      run(21'h30, 21'h34, 1'h0);
      chk(peek(12'h047), 32'h47);
      chk(peek(12'h210), 32'hFE);
      rchk(8'h08, 32'h1F);
      $display("t_bclr end");
   endtask
   // Word after each taken branch clears W if it ever executes
   task automatic t_branch;
      load(8'h40, 16'hE67F);
      load(8'h42, 16'hE205);
      load(8'h44, 16'h0B00);
      load(8'h60, 16'hE27F);
      load(8'h62, 16'hE6FB);
      load(8'h64, 16'h0B00);
      setup(8'hAA, 5'h01, 4'h0);
      run(21'h40, 21'h4E, 1'h0);
      rchk(8'h04, 32'hAA);
      rchk(8'h08, 32'h01);
      setup(8'hAA, 5'h10, 4'h0);
      run(21'h60, 21'h5A, 1'h0);
      rchk(8'h04, 32'hAA);
      rchk(8'h08, 32'h10);
      $display("t_branch end");
   endtask
   initial begin
      repeat (8) @(posedge clk);
      arst_n <= 1'h1;
      t_reset;
      t_addc;
      t_andl;
      t_andf;
      t_bclr;
      t_branch;
      tally_and_finish;
   end
endmodule // testbench
`default_nettype wire
